// File: hdl/link_rx_pkg.sv
package link_rx_pkg;
    localparam int unsigned LANES = 3;
    localparam int unsigned LANE_BITS = 7;
    localparam int unsigned WORD_BITS = LANES * LANE_BITS;
    localparam int unsigned REF_PERIOD_PS = 4000;
    localparam int unsigned PS_PER_US = 1000000;
    // lock range of the link clock
    localparam int unsigned LOCK_MIN_MHZ = 31;
    localparam int unsigned LOCK_MAX_MHZ = 68;
    // shortest period rounds up, longest rounds down
    localparam int unsigned MIN_PERIOD_CYC =
        (PS_PER_US + LOCK_MAX_MHZ * REF_PERIOD_PS - 1) /
        (LOCK_MAX_MHZ * REF_PERIOD_PS);
    localparam int unsigned MAX_PERIOD_CYC =
        PS_PER_US / (LOCK_MIN_MHZ * REF_PERIOD_PS);
    localparam int unsigned ENABLE_TIME_MS = 1;
    localparam int unsigned LOCK_CYCLES_DEF =
        ENABLE_TIME_MS * 1000 * PS_PER_US / REF_PERIOD_PS;
    localparam int unsigned DISABLE_TIME_NS = 400;
    localparam int unsigned DISABLE_CYCLES =
        DISABLE_TIME_NS * 1000 / REF_PERIOD_PS;
    localparam int unsigned FIFO_DEPTH_DEF = 16;
    localparam int unsigned PER_W = 8;
    localparam int unsigned ACC_W = 12;
    localparam int unsigned SLOT_W = 3;
    localparam int unsigned ACC_STEP = 2 * LANE_BITS;

    typedef struct packed {
        logic [LANES-1:0] pos;
        logic [LANES-1:0] neg;
    } lane_pins_t;

    typedef struct packed {
        logic [LANE_BITS-1:0] lane2;
        logic [LANE_BITS-1:0] lane1;
        logic [LANE_BITS-1:0] lane0;
    } word_t;
endpackage

// File: hdl/word_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
    parameter int unsigned WIDTH = 21,
    parameter int unsigned DEPTH = 16
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int unsigned PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg, rd_ptr_reg, rd_ptr_next;
    logic [PTR_W:0] count_reg;
    logic [WIDTH-1:0] rd_data_reg;
    logic wr, rd;

    assign in_ready_out = count_reg != (PTR_W+1)'(DEPTH);
    assign out_valid_out = count_reg != '0;
    assign wr = in_valid_in & in_ready_out;
    assign rd = out_valid_out & out_ready_in;
    assign rd_ptr_next = rd ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
    assign out_data_out = rd_data_reg;

    always_ff @(posedge clk_in) begin
        if (wr) begin
            mem[wr_ptr_reg] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (wr) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_reg + (PTR_W+1)'(wr) - (PTR_W+1)'(rd);
        end
    end

    // bypass the write into the head slot so data is never a cycle stale
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rd_data_reg <= '0;
        end else if (wr && wr_ptr_reg == rd_ptr_next) begin
            rd_data_reg <= in_data_in;
        end else begin
            rd_data_reg <= mem[rd_ptr_next];
        end
    end

    a_fifo_no_overfill: assert property (@(posedge clk_in) // R3
        disable iff (srst_in)
        !in_ready_out |=>
        count_reg == (PTR_W+1)'(DEPTH) - (PTR_W+1)'($past(rd)))
        else $error("fifo count moved past full");
endmodule
`default_nettype wire

// File: hdl/link_deser_rx.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1: Three independent shift registers each turn one serial lane into 7 bits.
// R2: Each lane is sampled seven times per link clock period.
// R3: Once per link period the three groups leave together as one 21-bit word.
// R4: A 7x sampling rate is derived from the link clock, with a word clock out.
// R5: The word is stable at the falling edge of the word clock for capture.
// R6: Shutdown low stops internal clocking and turns the line receivers off.
// R7: Shutdown low clears the internal registers and the output word to zero; the fifo memory array keeps its contents.
// R8: An undriven differential input reads as low, even when terminated.
// R9: Lock is only held while the link clock is within the supported range.
// R10: The transmitter keeps its mean link clock period inside the limits.
// R11: After shutdown rises, valid data waits about 1 ms for lock.
// R12: After shutdown falls, the off state is reached within about 400 ns.
// R13: Lane 0 feeds the lowest seven outputs, first serial bit lowest.
// R14: Each 7-bit group starts at a fixed phase of the link clock.
module link_deser_rx import link_rx_pkg::*; #(
    parameter int unsigned LOCK_CYCLES = LOCK_CYCLES_DEF,
    parameter int unsigned MIN_PERIOD = MIN_PERIOD_CYC,
    parameter int unsigned MAX_PERIOD = MAX_PERIOD_CYC,
    parameter int unsigned FIFO_DEPTH = FIFO_DEPTH_DEF
) (
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic shutdown_clear_n_in,
    input wire logic link_clock_pos_in,
    input wire logic link_clock_neg_in,
    input wire lane_pins_t lanes_in,
    input wire logic hold_in,
    output var word_t parallel_word_out,
    output logic word_clock_out,
    output logic lvds_enable_out,
    output logic link_locked_out,
    output logic overrun_out
);
    localparam int unsigned LOCK_W = $clog2(LOCK_CYCLES + 1);
    localparam logic [PER_W-1:0] MIN_P = PER_W'(MIN_PERIOD);
    localparam logic [PER_W-1:0] MAX_P = PER_W'(MAX_PERIOD);
    localparam logic [SLOT_W-1:0] LAST_SLOT = SLOT_W'(LANE_BITS - 1);
    localparam logic [SLOT_W-1:0] END_SLOT = SLOT_W'(LANE_BITS);
    localparam logic [ACC_W-1:0] STEP = ACC_W'(ACC_STEP);
    localparam logic [ACC_W-1:0] ACC_CAP = ACC_W'(ACC_STEP * 255);
    localparam int DIS_CYC = DISABLE_CYCLES;

    logic sd_meta_reg, sd_sync_reg;
    logic clk_meta_reg, clk_sync_reg, clk_prev_reg;
    logic [LANES-1:0] lane_meta_reg, lane_sync_reg;
    logic clear, link_rise;
    logic [PER_W-1:0] per_cnt_reg, period_reg;
    logic per_ok_reg;
    logic [LOCK_W-1:0] lock_cnt_reg;
    logic locked_reg, frame_on_reg;
    logic [ACC_W-1:0] acc_reg, target_reg;
    logic [SLOT_W-1:0] slot_reg;
    logic sample_stb;
    logic [LANES-1:0][LANE_BITS-1:0] shift_reg, shift_next;
    logic push_valid, push_ready, pop_valid, pop_ready, pop;
    word_t push_data, pop_data, word_reg;
    logic wclk_reg, overrun_reg;
    logic [PER_W-1:0] half_cnt_reg;

    assign clear = srst_in | ~sd_sync_reg; // R7
    // nothing moves once the clear is seen, even before the syncs reset
    assign link_rise = clk_sync_reg & ~clk_prev_reg & ~clear; // R6

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            sd_meta_reg <= 1'b0;
            sd_sync_reg <= 1'b0;
        end else begin
            sd_meta_reg <= shutdown_clear_n_in;
            sd_sync_reg <= sd_meta_reg;
        end
    end

    // receivers: held off while cleared, open pair (both low) reads as 0
    always_ff @(posedge ref_clk_in) begin
        if (clear) begin // R6
            clk_meta_reg <= 1'b0;
            clk_sync_reg <= 1'b0;
            clk_prev_reg <= 1'b0;
            lane_meta_reg <= '0;
            lane_sync_reg <= '0;
        end else begin
            clk_meta_reg <= link_clock_pos_in & ~link_clock_neg_in; // R8
            clk_sync_reg <= clk_meta_reg;
            clk_prev_reg <= clk_sync_reg;
            lane_meta_reg <= lanes_in.pos & ~lanes_in.neg; // R8
            lane_sync_reg <= lane_meta_reg;
        end
    end

    // period of the link clock in reference cycles
    always_ff @(posedge ref_clk_in) begin
        if (clear) begin
            per_cnt_reg <= '0;
            period_reg <= '0;
            per_ok_reg <= 1'b0;
        end else if (link_rise) begin
            per_cnt_reg <= PER_W'(1);
            period_reg <= per_cnt_reg;
            per_ok_reg <= per_cnt_reg >= MIN_P && per_cnt_reg <= MAX_P; // R9
        end else begin
            if (per_cnt_reg != '1) begin
                per_cnt_reg <= per_cnt_reg + 1'b1;
            end
            if (per_cnt_reg > MAX_P) begin
                per_ok_reg <= 1'b0; // R9
            end
        end
    end

    // lock stands in for the synthesizer settling time
    always_ff @(posedge ref_clk_in) begin
        if (clear || !per_ok_reg) begin
            lock_cnt_reg <= '0;
            locked_reg <= 1'b0;
        end else if (lock_cnt_reg == LOCK_W'(LOCK_CYCLES)) begin
            locked_reg <= 1'b1; // R11
        end else begin
            lock_cnt_reg <= lock_cnt_reg + 1'b1;
        end
    end

    // groups only start on a whole period, never mid-frame
    always_ff @(posedge ref_clk_in) begin
        if (clear || !locked_reg) begin
            frame_on_reg <= 1'b0;
        end else if (link_rise) begin
            frame_on_reg <= 1'b1; // R14
        end
    end

    // 7x sampling: acc grows 14 per cycle, sample k when acc >= (2k+1)P,
    // i.e. mid-bit; needs a period of at least 14 reference cycles
    assign sample_stb = frame_on_reg && locked_reg && !clear && !link_rise &&
        slot_reg < END_SLOT && acc_reg >= target_reg; // R2 R4

    always_ff @(posedge ref_clk_in) begin
        if (clear) begin
            acc_reg <= '0;
            target_reg <= '0;
            slot_reg <= '0;
        end else if (link_rise) begin
            acc_reg <= STEP; // R14
            target_reg <= ACC_W'(per_cnt_reg);
            slot_reg <= '0;
        end else begin
            if (acc_reg < ACC_CAP) begin
                acc_reg <= acc_reg + STEP;
            end
            if (sample_stb) begin
                target_reg <= target_reg + ACC_W'({period_reg, 1'b0});
                slot_reg <= slot_reg + 1'b1;
            end
        end
    end

    // first serial bit ends in bit 0 after seven shifts
    always_comb begin
        for (int i = 0; i < LANES; i++) begin
            shift_next[i] = {lane_sync_reg[i], shift_reg[i][LANE_BITS-1:1]};
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (clear) begin
            shift_reg <= '0; // R7
        end else if (sample_stb) begin
            shift_reg <= shift_next; // R1
        end
    end

    assign push_valid = sample_stb && slot_reg == LAST_SLOT; // R3
    assign push_data = word_t'(shift_next); // R13

    word_fifo #(
        .WIDTH(WORD_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_in(ref_clk_in),
        .srst_in(clear),
        .in_valid_in(push_valid),
        .in_ready_out(push_ready),
        .in_data_in(push_data),
        .out_valid_out(pop_valid),
        .out_ready_in(pop_ready),
        .out_data_out(pop_data)
    );

    // a full fifo cannot stall the serial line, so the word is lost
    always_ff @(posedge ref_clk_in) begin
        if (clear) begin
            overrun_reg <= 1'b0;
        end else begin
            overrun_reg <= push_valid & ~push_ready;
        end
    end

    assign pop_ready = frame_on_reg & link_rise & ~hold_in; // R3
    assign pop = pop_valid & pop_ready;

    // word clock high for half a period, word changes only on its rise
    always_ff @(posedge ref_clk_in) begin
        if (clear) begin
            word_reg <= '0; // R7
            wclk_reg <= 1'b0;
            half_cnt_reg <= '0;
        end else if (pop) begin
            word_reg <= pop_data; // R3
            wclk_reg <= 1'b1; // R4
            half_cnt_reg <= per_cnt_reg >> 1;
        end else if (half_cnt_reg != '0) begin
            half_cnt_reg <= half_cnt_reg - 1'b1;
            if (half_cnt_reg == PER_W'(1)) begin
                wclk_reg <= 1'b0; // R5
            end
        end
    end

    assign parallel_word_out = word_reg;
    assign word_clock_out = wclk_reg;
    assign lvds_enable_out = sd_sync_reg; // R6 R12
    assign link_locked_out = locked_reg;
    assign overrun_out = overrun_reg;

    a_clear_word_zero: assert property (@(posedge ref_clk_in) // R7
        disable iff (srst_in)
        !sd_sync_reg |=> parallel_word_out == '0 && !word_clock_out)
        else $error("output not cleared under shutdown");

    a_clear_shift_zero: assert property (@(posedge ref_clk_in) // R7
        disable iff (srst_in)
        !sd_sync_reg |=> shift_reg == '0 && acc_reg == '0 && !pop_valid)
        else $error("internal state not cleared under shutdown");

    a_off_no_clocking: assert property (@(posedge ref_clk_in) // R6
        disable iff (srst_in)
        !sd_sync_reg |-> !sample_stb && !pop && !link_rise)
        else $error("internal clocking active under shutdown");

    a_disable_time: assert property (@(posedge ref_clk_in) // R12
        disable iff (srst_in)
        $fell(shutdown_clear_n_in) ##1 !shutdown_clear_n_in[*3]
        |-> ##[0:DIS_CYC] !lvds_enable_out)
        else $error("receivers not off in time");

    a_lock_gates_sample: assert property (@(posedge ref_clk_in) // R11
        disable iff (srst_in)
        !link_locked_out |-> !sample_stb ##1 !push_valid)
        else $error("sampling before lock");

    a_range_lock: assert property (@(posedge ref_clk_in) // R9
        disable iff (srst_in)
        link_rise && (per_cnt_reg < MIN_P || per_cnt_reg > MAX_P)
        |=> !per_ok_reg ##1 !link_locked_out)
        else $error("lock held on out of range clock");

    a_seven_slots: assert property (@(posedge ref_clk_in) // R2
        disable iff (srst_in)
        sample_stb && slot_reg == LAST_SLOT |=>
        !sample_stb && slot_reg == END_SLOT)
        else $error("more than seven samples in a period");

    a_overrun_pulse: assert property (@(posedge ref_clk_in) // R3
        disable iff (srst_in)
        push_valid && !push_ready |=> overrun_out)
        else $error("dropped word not flagged");

    a_word_launch: assert property (@(posedge ref_clk_in) // R5
        disable iff (srst_in)
        pop |=> word_clock_out && parallel_word_out == $past(pop_data))
        else $error("word and word clock not launched together");

    a_slot_align: assert property (@(posedge ref_clk_in) // R14
        disable iff (srst_in)
        link_rise |=> slot_reg == '0 && acc_reg == STEP)
        else $error("group not aligned to link clock rise");

    a_lane_shift: assert property (@(posedge ref_clk_in) // R1
        disable iff (srst_in)
        sample_stb |=> shift_reg[1][LANE_BITS-1] == $past(lane_sync_reg[1])
        && shift_reg[0][LANE_BITS-2:0] == $past(shift_reg[0][LANE_BITS-1:1]))
        else $error("lane shift register wrong");

    a_word_per_rise: assert property (@(posedge ref_clk_in) // R3
        disable iff (srst_in)
        $rose(word_clock_out) |-> $past(link_rise) && $past(frame_on_reg))
        else $error("word issued off the link clock rise");

    a_word_at_fall: assert property (@(posedge ref_clk_in) // R5
        disable iff (srst_in)
        $fell(word_clock_out) |-> $stable(parallel_word_out)
        ##1 $stable(parallel_word_out))
        else $error("word moved around word clock fall");

    a_open_reads_low: assert property (@(posedge ref_clk_in) // R8
        disable iff (srst_in)
        (lanes_in.pos == '0 && lanes_in.neg == '0) [*3]
        |-> lane_sync_reg == '0)
        else $error("open lane did not read low");
endmodule
`default_nettype wire

// File: verif/link_tx_model.sv
`timescale 1ns/1ps
`default_nettype none
module link_tx_model import link_rx_pkg::*; #(
    parameter realtime HALF_NS = 40.0,
    parameter realtime LAG_NS = 2.0
) (
    input wire logic run_in,
    input wire logic [LANES-1:0] float_in,
    output logic clk_pos_out,
    output logic clk_neg_out,
    output var lane_pins_t lanes_out,
    output logic idle_out
);
    word_t tx_q[$];
    word_t cur;

    task automatic send(input word_t w);
        tx_q.push_back(w);
        idle_out = 1'b0;
    endtask

    // the receiver already allows for its sync lag; a small lag centres samples
    task automatic serial(input word_t w);
        #(LAG_NS);
        for (int k = 0; k < LANE_BITS; k++) begin
            for (int i = 0; i < LANES; i++) begin
                lanes_out.pos[i] = w[i*LANE_BITS+k] & ~float_in[i];
                lanes_out.neg[i] = ~w[i*LANE_BITS+k] & ~float_in[i];
            end
            #(2.0 * HALF_NS / LANE_BITS);
        end
    endtask

    initial begin
        clk_pos_out = 1'b0;
        clk_neg_out = 1'b1;
        lanes_out = {{LANES{1'b0}}, {LANES{1'b1}}};
        idle_out = 1'b1;
        cur = '0;
        #1.3;
        forever begin
            // clock stands low while stopped; empty queue sends zero words
            while (!run_in) #(HALF_NS);
            cur = (tx_q.size() != 0) ? tx_q.pop_front() : '0;
            idle_out = (tx_q.size() == 0);
            fork
                serial(cur);
            join_none
            clk_pos_out = 1'b1;
            clk_neg_out = 1'b0;
            #(HALF_NS);
            clk_pos_out = 1'b0;
            clk_neg_out = 1'b1;
            #(HALF_NS);
        end
    end
endmodule
`default_nettype wire

// File: verif/link_deser_rx_bench.sv
`timescale 1ns/1ps
`default_nettype none
module link_deser_rx_bench import link_rx_pkg::*;;
    localparam int P = 20;
    logic ref_clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic shutdown_clear_n_in = 1'b1;
    logic hold_in = 1'b0;
    logic run = 1'b1;
    logic [LANES-1:0] float_lanes = '0;
    logic clk_p;
    logic clk_n;
    logic idle;
    logic word_clock_out;
    logic lvds_enable_out;
    logic link_locked_out;
    logic overrun_out;
    logic wc_prev = 1'b0;
    lane_pins_t lanes;
    word_t parallel_word_out;
    word_t seen_rise;
    word_t exp_q[$];
    int err_total = 0;
    int n_checks = 0;
    int hi_cnt = 0;
    int n_ovr = 0;
    int seed = 32'h981A2258;

    always #2 ref_clk_in = ~ref_clk_in;

    link_tx_model i_link_tx_model (
        .run_in(run),
        .float_in(float_lanes),
        .clk_pos_out(clk_p),
        .clk_neg_out(clk_n),
        .lanes_out(lanes),
        .idle_out(idle)
    );

    // bench link clock is slow, so the in-range ceiling is widened
    link_deser_rx #(.LOCK_CYCLES(20), .MAX_PERIOD(32)) i_link_deser_rx (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in),
        .shutdown_clear_n_in(shutdown_clear_n_in),
        .link_clock_pos_in(clk_p),
        .link_clock_neg_in(clk_n),
        .lanes_in(lanes),
        .hold_in(hold_in),
        .parallel_word_out(parallel_word_out),
        .word_clock_out(word_clock_out),
        .lvds_enable_out(lvds_enable_out),
        .link_locked_out(link_locked_out),
        .overrun_out(overrun_out)
    );

    task automatic check(input string what, input logic [WORD_BITS-1:0] seen,
                         input logic [WORD_BITS-1:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic step(inout int n, input int lim, input string what);
        @(negedge ref_clk_in);
        n++;
        if (n > lim) begin
            check(what, '0, '1);
            wrap_up();
        end
    endtask

    task automatic send(input word_t v, input bit keep);
        if (keep)
            exp_q.push_back(v);
        i_link_tx_model.send(v);
    endtask

    function automatic word_t rnd;
        word_t v;
        v = WORD_BITS'($random(seed));
        return (v == '0) ? WORD_BITS'(1) : v;
    endfunction

    task automatic drain;
        int n;
        n = 0;
        while (exp_q.size() != 0 || !idle)
            step(n, 4000, "drain");
        repeat (3 * P) @(negedge ref_clk_in);
    endtask

    task automatic relock;
        int n;
        n = 0;
        while (link_locked_out !== 1'b1)
            step(n, 500, "relock");
        check("lock delay", WORD_BITS'(n > 20), WORD_BITS'(1));
        check("receivers on", WORD_BITS'(lvds_enable_out), WORD_BITS'(1));
        repeat (4 * P) @(negedge ref_clk_in);
    endtask

    // zero words are the model's idle filler and are not scored
    always @(negedge ref_clk_in) begin
        if (overrun_out === 1'b1)
            n_ovr <= n_ovr + 1;
        if (word_clock_out === 1'b1)
            hi_cnt <= hi_cnt + 1;
        if (word_clock_out === 1'b1 && wc_prev !== 1'b1)
            seen_rise <= parallel_word_out;
        if (word_clock_out !== 1'b1 && wc_prev === 1'b1) begin
            hi_cnt <= 0;
            if (parallel_word_out !== '0) begin
                check("clock high", WORD_BITS'(hi_cnt), WORD_BITS'(P / 2));
                check("stable", parallel_word_out, seen_rise);
                if (exp_q.size() == 0)
                    check("extra word", parallel_word_out, '0);
                else
                    check("word", parallel_word_out, exp_q.pop_front());
            end
        end
        wc_prev <= word_clock_out;
    end

    initial begin
        int n;
        repeat (3) @(negedge ref_clk_in);
        srst_in = 1'b0;
        @(negedge ref_clk_in);
        check("reset word", parallel_word_out, '0);
        check("reset lock", WORD_BITS'(link_locked_out), '0);
        relock();
        for (int i = 0; i < WORD_BITS; i++)
            send(WORD_BITS'(32'h1 << i), 1'b1);
        for (int i = 0; i < 16; i++)
            send(rnd(), 1'b1);
        drain();
        float_lanes = 3'h2;
        exp_q.push_back(21'h1FC07F);
        send(21'h1FFFFF, 1'b0);
        drain();
        // every lane open: the word must arrive as zero and go unscored
        float_lanes = '1;
        send(rnd(), 1'b0);
        drain();
        float_lanes = '0;
        // stall just after a pop so the buffer starts empty
        n = 0;
        while (word_clock_out !== 1'b0)
            step(n, 4 * P, "clock low");
        while (word_clock_out !== 1'b1)
            step(n, 4 * P, "clock high");
        hold_in = 1'b1;
        for (int j = 0; j < 20; j++)
            send(rnd(), j < 15);
        n = n_ovr;
        repeat (25 * P) @(negedge ref_clk_in);
        check("overruns", WORD_BITS'(n_ovr - n >= 5), WORD_BITS'(1));
        check("held clock", WORD_BITS'(hi_cnt), '0);
        hold_in = 1'b0;
        drain();
        shutdown_clear_n_in = 1'b0;
        for (int j = 0; j < 3; j++)
            send(rnd(), 1'b0);
        repeat (5) @(negedge ref_clk_in);
        check("off state", WORD_BITS'({lvds_enable_out, link_locked_out,
              word_clock_out}), '0);
        check("cleared word", parallel_word_out, '0);
        n = 0;
        while (!idle)
            step(n, 400, "idle");
        repeat (2 * P) @(negedge ref_clk_in);
        shutdown_clear_n_in = 1'b1;
        relock();
        for (int j = 0; j < 4; j++)
            send(rnd(), 1'b1);
        drain();
        run = 1'b0;
        n = 0;
        while (link_locked_out !== 1'b0)
            step(n, 100, "lock drop");
        run = 1'b1;
        relock();
        for (int j = 0; j < 4; j++)
            send(rnd(), 1'b1);
        drain();
        check("leftover", WORD_BITS'(exp_q.size()), '0);
        wrap_up();
    end
endmodule
`default_nettype wire
